// *** hdl/dog_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: counter clock is main/16, /64, /256 or /1024 per select code.
// R2: overflow every 2^11, 2^13, 2^15 or 2^17 main clocks.
// R3: clock select is byte-written, resets to zero, upper five bits read zero.
// R4: run bit zero stops counting; writing one clears and starts.
// R5: run bit cannot be cleared by software; rewriting one restarts count.
// R6: mode bits pick stop, interval irq, nmi or reset on overflow.
// R7: mode bits are set-only, cleared by reset only.
// R8: interval mode counts after run set, interrupts on every overflow.
// R9: first overflow after restart may be early; prescaler is not cleared.
// R10: software checks irq flag is zero before enabling loop detection.
// R11: loop detect set while irq flag is one raises nmi at once.
// R12: mode register takes bit or byte writes; bits 6,5,2,1,0 zero.
// R13: counter runs in halt state, stops in stop state.
// R14: counter frozen while subsystem clock feeds the cpu.
// R15: interval irq gated by its mask flag, highest maskable priority.
// R16: seven-bit up-counter; wrap to zero is the overflow.
// R17: each overflow pulses the chosen request and sets the irq flag; with the stop action the code sets no flag.
module dog_timer
  import dog_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_bit_wr,
  input  wire logic [2:0]  i_bit_pos,
  input  wire logic        i_rd,
  input  wire logic        i_cpu_halt,
  input  wire logic        i_cpu_stop,
  input  wire logic        i_cpu_on_subclk,
  input  wire logic        i_dog_irq_mask,
  input  wire logic        i_dog_irq_flag_clr,
  output logic [7:0]       o_rdata,
  output logic             o_dog_irq_flag,
  output logic             o_dog_interval_irq,
  output logic             o_nmi_req,
  output logic             o_reset_req
);
  // ==========================================================
  // state
  logic [2:0]             clock_sel_r;
  logic [2:0]             clock_sel_nxt;
  logic                   run_r;
  logic                   run_nxt;
  logic                   loop_r;
  logic                   loop_nxt;
  logic                   action_r;
  logic                   action_nxt;
  logic [COUNT_WIDTH-1:0] count_r;
  logic [COUNT_WIDTH-1:0] count_nxt;
  logic                   flag_nxt;
  logic                   ival_nxt;
  logic                   nmi_nxt;
  logic                   rst_nxt;
  logic [7:0]             rdata_nxt;
  logic                   tick;
  logic                   advance;
  logic                   hit_sel;
  logic                   hit_mode;
  logic [7:0]             mode_wval;
  logic                   overflow;
  logic                   restart;
  action_type             action;

  // ==========================================================
  // helpers shared by the write decode and the read mux
  function automatic logic is_sel_addr(logic [15:0] a);
    return a == ADDR_CLOCK_SELECT;
  endfunction : is_sel_addr

  function automatic logic is_mode_addr(logic [15:0] a);
    return a == ADDR_MODE_CONTROL;
  endfunction : is_mode_addr

  // one image for read-back and bit-write base, so they never disagree;
  // unused bit positions stay tied low
  function automatic logic [7:0] mode_image(logic run,
                                            logic loop,
                                            logic act);
    logic [7:0] img;
    img             = 8'h00;
    img[RUN_BIT]    = run;
    img[LOOP_BIT]   = loop;
    img[ACTION_BIT] = act;
    return img;
  endfunction : mode_image

  // halt is taken only for completeness: the count runs through it,
  // so no logic needs to look at that input
  // halt keeps counting; stop and subclock freeze the prescaler and the counter
  assign advance = !i_cpu_stop && !i_cpu_on_subclk; // R13 R14

  dog_prescaler #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_pre (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_advance (advance),
    .i_select  (clock_sel_r),
    .o_tick    (tick)
  );

  // ==========================================================
  // register write decode
  always_comb begin
    hit_sel  = 1'b0;
    hit_mode = 1'b0;
    if (is_sel_addr(i_addr)) begin
      hit_sel = i_wr; // R3
    end else if (is_mode_addr(i_addr)) begin
      hit_mode = i_wr || i_bit_wr; // R12
    end
    // a bit write only sets or clears the addressed bit
    mode_wval = mode_image(run_r, loop_r, action_r);
    if (i_bit_wr) begin
      mode_wval[i_bit_pos] = i_wdata[0];
    end else begin
      mode_wval = i_wdata;
    end
  end

  // ==========================================================
  // control bits: mode bits set-only, so ones simply or in; clock select loads as written
  always_comb begin
    clock_sel_nxt = hit_sel ? i_wdata[SEL_MSB:0] : clock_sel_r; // R3
    run_nxt    = run_r    | (hit_mode & mode_wval[RUN_BIT]);    // R5
    loop_nxt   = loop_r   | (hit_mode & mode_wval[LOOP_BIT]);   // R7
    action_nxt = action_r | (hit_mode & mode_wval[ACTION_BIT]); // R7
    // a bit write aimed at another bit must not restart a running count
    restart    = hit_mode & mode_wval[RUN_BIT] &
                 (!i_bit_wr || i_bit_pos == 3'(RUN_BIT));       // R4 R5
  end

  // ==========================================================
  // counter and overflow actions
  always_comb begin
    action    = action_type'({loop_r, action_r}); // R6
    // tick was launched a cycle earlier; gating it again makes a freeze
    // take hold at once instead of letting one last tick through
    overflow  = run_r && !restart && tick && advance &&
                (count_r == {COUNT_WIDTH{1'b1}}); // R16 R2 R13 R14
    count_nxt = count_r;
    if (restart) begin
      count_nxt = '0; // R4 R9
    end else if (run_r && tick && advance) begin
      count_nxt = count_r + 1'b1; // R16 R8
    end
    ival_nxt = overflow && action == ACT_INTERVAL && !i_dog_irq_mask; // R15
    // nmi also fires when loop detect is newly set over a pending flag
    nmi_nxt  = (overflow && action == ACT_NMI) ||
               (hit_mode && mode_wval[LOOP_BIT] && !loop_r &&
                o_dog_irq_flag); // R11
    rst_nxt  = overflow && action == ACT_RESET; // R17
    // set beats clear
    flag_nxt = (overflow && action != ACT_STOP) ||
               (o_dog_irq_flag && !i_dog_irq_flag_clr); // R17
  end

  // ==========================================================
  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd && is_sel_addr(i_addr)) begin
      rdata_nxt = {5'h00, clock_sel_r}; // R3
    end else if (i_rd && is_mode_addr(i_addr)) begin
      rdata_nxt = mode_image(run_r, loop_r, action_r); // R12
    end
  end

  // ==========================================================
  // register stage: software-visible control bits
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clock_sel_r <= RESET_CLOCK_SELECT[SEL_MSB:0];
      run_r       <= RESET_MODE_CONTROL[RUN_BIT];
      loop_r      <= RESET_MODE_CONTROL[LOOP_BIT];
      action_r    <= RESET_MODE_CONTROL[ACTION_BIT];
    end else begin
      clock_sel_r <= clock_sel_nxt;
      run_r       <= run_nxt;
      loop_r      <= loop_nxt;
      action_r    <= action_nxt;
    end
  end

  // register stage: overflow counter
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // register stage: request pulses and flag, all straight from flops
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dog_irq_flag     <= 1'b0;
      o_dog_interval_irq <= 1'b0;
      o_nmi_req          <= 1'b0;
      o_reset_req        <= 1'b0;
    end else begin
      o_dog_irq_flag     <= flag_nxt;
      o_dog_interval_irq <= ival_nxt;
      o_nmi_req          <= nmi_nxt;
      o_reset_req        <= rst_nxt;
    end
  end

  // register stage: read data, held one cycle only
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end
endmodule : dog_timer
`default_nettype wire

// *** hdl/dog_pkg.sv ***
package dog_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hff42;
  localparam logic [15:0] ADDR_MODE_CONTROL = 16'hfff9;
  localparam logic [7:0]  RESET_CLOCK_SELECT = 8'h00;
  localparam logic [7:0]  RESET_MODE_CONTROL = 8'h00;
  // ==========================================================
  // field positions
  localparam int RUN_BIT       = 7;
  localparam int LOOP_BIT      = 4;
  localparam int ACTION_BIT    = 3;
  localparam int SEL_MSB       = 2;
  // ==========================================================
  // clock selection codes and prescaler taps
  localparam logic [2:0] SEL_DIV16   = 3'h0;
  localparam logic [2:0] SEL_DIV64   = 3'h2;
  localparam logic [2:0] SEL_DIV256  = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h6;
  localparam int PRESCALE_WIDTH = 10;
  localparam int COUNT_WIDTH    = 7;
  // ==========================================================
  // overflow actions
  typedef enum logic [1:0] {
    ACT_STOP     = 2'h0,
    ACT_INTERVAL = 2'h1,
    ACT_NMI      = 2'h2,
    ACT_RESET    = 2'h3
  } action_type;
endpackage : dog_pkg

// *** hdl/dog_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
// prescaler, held while i_advance is low; tick pulses once per selected divide
module dog_prescaler
  import dog_pkg::*;
#(
  parameter int WIDTH = dog_pkg::PRESCALE_WIDTH
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_advance,
  input  wire logic [2:0] i_select,
  output logic            o_tick
);
  logic [WIDTH-1:0] pre_r;
  logic [WIDTH-1:0] pre_nxt;
  logic             tick_nxt;
  logic [WIDTH-1:0] mask;

  // ==========================================================
  // divider; never cleared by software, hence the early first overflow
  always_comb begin
    case (i_select)
      SEL_DIV64:   mask = WIDTH'(10'h03f);
      SEL_DIV256:  mask = WIDTH'(10'h0ff);
      SEL_DIV1024: mask = WIDTH'(10'h3ff);
      default:     mask = WIDTH'(10'h00f); // R1
    endcase
    pre_nxt  = i_advance ? pre_r + 1'b1 : pre_r;
    tick_nxt = i_advance && ((pre_r & mask) == mask); // R1
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule : dog_prescaler
`default_nettype wire

// *** bench/dog_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module dog_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic [15:0] i_addr,
  input wire logic        i_rd,
  input wire logic        i_cpu_stop,
  input wire logic        i_cpu_on_subclk,
  input wire logic        i_dog_irq_mask,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_dog_irq_flag,
  input wire logic        o_dog_interval_irq,
  input wire logic        o_nmi_req,
  input wire logic        o_reset_req
);
  // ==========================================================
  // checks; reset masks everything
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic [2:0] req = {o_dog_interval_irq, o_nmi_req, o_reset_req};
  property p_unmap; i_rd && i_addr != 16'hff42 && i_addr != 16'hfff9
    |=> o_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_sel; i_rd && i_addr == 16'hff42 |=> o_rdata[7:3] == 5'h00;
  endproperty
  a_sel: assert property (p_sel) else $error("select high bits");
  property p_mode; i_rd && i_addr == 16'hfff9 |=> !(|(o_rdata & 8'h67));
  endproperty
  a_mode: assert property (p_mode) else $error("mode fixed bits");
  property p_pulse; req != 3'h0 |=> req == 3'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_one; $onehot0(req); endproperty
  a_one: assert property (p_one) else $error("two actions");
  property p_flag; req != 3'h0 |-> o_dog_irq_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_mask; i_dog_irq_mask ##1 i_dog_irq_mask |-> !o_dog_interval_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_frz; (i_cpu_stop || i_cpu_on_subclk) [*2] |-> req == 3'h0;
  endproperty
  a_frz: assert property (p_frz) else $error("frozen req");
endmodule : dog_monitor
bind dog_timer dog_monitor u_dog_monitor (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_rd(i_rd),
  .i_cpu_stop(i_cpu_stop), .i_cpu_on_subclk(i_cpu_on_subclk),
  .i_dog_irq_mask(i_dog_irq_mask), .o_rdata(o_rdata),
  .o_dog_irq_flag(o_dog_irq_flag), .o_dog_interval_irq(o_dog_interval_irq),
  .o_nmi_req(o_nmi_req), .o_reset_req(o_reset_req));
`default_nettype wire

// *** bench/dog_sys_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// system side: acks the flag some cycles after each request
module dog_sys_model #(
  parameter int LAT = 3
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [2:0] i_req,
  output logic            o_dog_irq_flag_clr
);
  logic [7:0] ack_r;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) ack_r <= 8'h00;
    else ack_r <= {ack_r[6:0], |i_req};
  end
  assign o_dog_irq_flag_clr = ack_r[LAT];
endmodule : dog_sys_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 0, rst = 1, wr = 0, bwr = 0, rd = 0, halt = 0;
  logic        stp = 0, sub = 0, mask = 0, clr, flag;
  logic [15:0] addr = 0;
  logic [7:0]  wdata = 0, rdata;
  logic [2:0]  bpos = 0, c;
  wire  [2:0]  req;
  logic [31:0] rnd = 32'h3d674f1c;
  int          mismatches = 0, comparisons = 0, n;
  dog_timer u_dog_timer (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_bit_wr(bwr), .i_bit_pos(bpos), .i_rd(rd),
    .i_cpu_halt(halt), .i_cpu_stop(stp), .i_cpu_on_subclk(sub),
    .i_dog_irq_mask(mask), .i_dog_irq_flag_clr(clr), .o_rdata(rdata),
    .o_dog_irq_flag(flag), .o_dog_interval_irq(req[2]), .o_nmi_req(req[1]),
    .o_reset_req(req[0]));
  dog_sys_model u_dog_sys_model (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_req(req), .o_dog_irq_flag_clr(clr));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic int per(logic [2:0] s);
    return 2048 << s;
  endfunction : per
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wreg(logic [15:0] a, logic [7:0] d, logic b, logic [2:0] p);
    @(posedge clk);
    {addr, wdata, wr, bwr, bpos} <= {a, d, !b, b, p};
    @(posedge clk);
    {wr, bwr} <= 2'h0;
  endtask : wreg
  task automatic rchk(string s, logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(s, e, rdata);
  endtask : rchk
  // waits for any request pulse, n = cycles waited (lim = none seen)
  task automatic wpulse(int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req === 3'h0 && n < lim);
  endtask : wpulse
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ==========================================================
  // clock, random halt level (counting must not care)
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    halt <= rnd[3];
  end
  initial begin
    #900000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk("sel", 16'hff42, 8'h00);
    rchk("mode", 16'hfff9, 8'h00);
    rchk("unmap", 16'hff43, 8'h00);
    // only the two shorter periods, so the whole run stays short
    c = {1'b0, rnd[0], 1'b0};
    wreg(16'hff42, {rnd[15:11], c}, 0, 0);
    rchk("sel", 16'hff42, {5'h0, c});
    wreg(16'hfff9, 8'h08 | (rnd[7:0] & 8'h67), 0, 0);
    rchk("mode", 16'hfff9, 8'h08);
    wpulse(per(c) + 9);
    chk("idle", 0, req);
    wreg(16'hfff9, 8'h88, 0, 0);
    wpulse(per(c) + 9);
    chk("first", 1, n <= per(c) + 3);
    chk("kind", 4'h9, {req, flag});
    wpulse(per(c) + 9);
    chk("period", per(c), n);
    wreg(16'hfff9, 8'h00, 0, 0);
    wreg(16'hfff9, 8'h00, 1, 3'h7);
    rchk("mode", 16'hfff9, 8'h88);
    repeat (per(c) / 2) @(posedge clk);
    wreg(16'hfff9, 8'h88, 0, 0);
    wpulse(per(c) + 9);
    chk("restart", 1, n > per(c) * 3 / 4);
    @(posedge clk) mask <= 1'b1;
    wpulse(per(c) + 9);
    chk("masked", 2'h1, {|req, flag});
    for (int i = 0; i < 2; i++) begin
      // unmasked, so a count that failed to freeze would show a pulse
      @(posedge clk) {stp, sub, mask} <= {i == 0, i == 1, 1'b0};
      wpulse(per(c) + 9);
      chk("frozen", 0, req);
    end
    @(posedge clk) {stp, sub} <= 2'h0;
    wreg(16'hfff9, 8'h01, 1, 3'h4);
    wpulse(6);
    chk("nmi_now", 3'h2, req);
    wpulse(per(c) + 9);
    chk("rst_req", 3'h1, req);
    @(posedge clk) {rst, mask} <= 2'h2;
    @(posedge clk) rst <= 1'b0;
    @(negedge clk);
    chk("flag", 0, flag);
    wreg(16'hfff9, 8'h90, 0, 0);
    wpulse(per(0) + 9);
    chk("nmi", 4'h5, {req, flag});
    wreg(16'hfff9, 8'h00, 1, 3'h4);
    rchk("mode", 16'hfff9, 8'h90);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
